//--- pkg/wcd_pkg.sv
// Shared constants, types and register map of the watchdog-clear and decrement executor.
package wcd_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses on the AXI4-Lite slave)
	// ------------------------------------------------------------------
	localparam int unsigned AXI_ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_WREG = 8'h08;
	localparam logic [7:0] OFF_FADDR = 8'h0c;
	localparam logic [7:0] OFF_FDATA = 8'h10;
	localparam logic [7:0] OFF_WDOG = 8'h14;
	localparam logic [7:0] OFF_PRESC = 8'h18;

	localparam int unsigned CTRL_W = 2;
	localparam int unsigned CTRL_EXEC_BIT = 0;
	localparam int unsigned CTRL_WDOG_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;

	localparam int unsigned STAT_ZERO_BIT = 2;
	localparam int unsigned STAT_PWRDN_BIT = 3;
	localparam int unsigned STAT_TMO_BIT = 4;
	localparam logic STAT_TMO_RST = 1'b1;
	localparam logic STAT_PWRDN_RST = 1'b1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// Instruction encodings
	// ------------------------------------------------------------------
	localparam int unsigned INSTR_W = 14;
	localparam logic [13:0] OPC_WDOG_CLEAR = 14'h0064;
	localparam logic [5:0] OPC_DEC = 6'h03;
	localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
	localparam int unsigned OPC_LSB = 8;
	localparam int unsigned DEST_BIT = 7;
	localparam int unsigned FADDR_W = 7;
	localparam int unsigned FILE_DEPTH = 128;

	// ------------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------------
	localparam logic [7:0] WDOG_CLEAR_VAL = 8'h00;
	localparam logic [7:0] PRESC_CLEAR_VAL = 8'h00;
	localparam logic [7:0] PRESC_LAST = 8'hff;
	localparam logic [7:0] WDOG_LAST = 8'hff;

	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_WDOG_CLEAR = 2'b01,
		OP_DEC = 2'b10,
		OP_DEC_SKIP = 2'b11
	} wcd_op_e;

	typedef enum logic {
		EX_RUN = 1'b0,
		EX_SKIP = 1'b1
	} wcd_exst_e;

	typedef struct packed {
		wcd_op_e op;
		logic dest;
		logic [6:0] faddr;
	} wcd_dec_s;

	typedef struct packed {
		logic timeout_flag;
		logic power_down_flag;
		logic zero_flag;
	} wcd_flags_s;

	typedef struct packed {
		logic [7:0] presc;
		logic [7:0] count;
		logic timeout;
	} wcd_wdog_s;

	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] ctrl;
		logic [7:0] wreg;
		logic [6:0] faddr;
		wcd_flags_s flags;
		wcd_exst_e ex;
		logic discard;
	} wcd_state_s;

endpackage

//--- rtl/wcd_decode.sv
// Instruction decoder for the watchdog-clear and decrement operations.
module wcd_decode
	import wcd_pkg::*;
(
	input wire logic [13:0] instr,
	output wcd_dec_s dec
);

	always_comb begin
		dec.dest = instr[DEST_BIT];
		dec.faddr = instr[FADDR_W-1:0];
		if (instr == OPC_WDOG_CLEAR) begin
			dec.op = OP_WDOG_CLEAR;
		end else if (instr[13:OPC_LSB] == OPC_DEC) begin
			dec.op = OP_DEC;
		end else if (instr[13:OPC_LSB] == OPC_DEC_SKIP) begin
			dec.op = OP_DEC_SKIP;
		end else begin
			dec.op = OP_NONE;
		end
	end

endmodule

//--- rtl/wcd_wdog.sv
// Watchdog counter with its prescaler and clear input.
module wcd_wdog
	import wcd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic clear,
	output logic [7:0] count,
	output logic [7:0] presc,
	output logic timeout
);

	wcd_wdog_s st_q;
	wcd_wdog_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.timeout = 1'b0;
		if (clear) begin
			// Clearing both stages restarts the full period from the start.
			st_d.count = WDOG_CLEAR_VAL;
			st_d.presc = PRESC_CLEAR_VAL;
		end else if (enable) begin
			st_d.presc = st_q.presc + 8'h01;
			if (st_q.presc == PRESC_LAST) begin
				st_d.count = st_q.count + 8'h01;
				st_d.timeout = (st_q.count == WDOG_LAST);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign count = st_q.count;
	assign presc = st_q.presc;
	assign timeout = st_q.timeout;

endmodule

//--- rtl/wcd_exec.sv
// Executor for watchdog-clear, decrement and decrement-skip, with AXI4-Lite registers.
module wcd_exec
	import wcd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [13:0] instr_word,
	input wire logic instr_valid,
	output logic instr_ready,
	output logic skip_discard,
	output wcd_flags_s flags,
	output logic wdog_timeout
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	wcd_state_s st_q;
	wcd_state_s st_d;
	wcd_dec_s dec;
	logic [7:0] file_mem [FILE_DEPTH];
	logic [7:0] file_rd;
	logic [7:0] file_sw_rd;
	logic [7:0] dec_res;
	logic fw_en;
	logic [6:0] fw_addr;
	logic [7:0] fw_data;
	logic wd_clear;
	logic wd_timeout;
	logic [7:0] wd_count;
	logic [7:0] wd_presc;
	logic take;
	logic [31:0] rd_word;
	logic rd_err;
	logic wr_exec;
	logic rd_take;
	logic skip_armed;

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr[7:2] == off[7:2]);
	endfunction

	function automatic logic is_zero(input logic [7:0] val);
		is_zero = (val == 8'h00);
	endfunction

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------
	wcd_decode u_decode (
		.instr(instr_word),
		.dec(dec)
	);

	wcd_wdog u_wdog (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(st_q.ctrl[CTRL_WDOG_BIT]),
		.clear(wd_clear),
		.count(wd_count),
		.presc(wd_presc),
		.timeout(wd_timeout)
	);

	// ------------------------------------------------------------------
	// File register array
	// ------------------------------------------------------------------
	// The array holds data only, so it is not reset; software loads it
	// before running instructions that read it.
	always_ff @(posedge aclk) begin
		if (fw_en) begin
			file_mem[fw_addr] <= fw_data;
		end
	end

	assign file_rd = file_mem[dec.faddr];
	assign file_sw_rd = file_mem[st_q.faddr];
	assign dec_res = file_rd - 8'h01;

	// ------------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------------
	assign instr_ready = st_q.ctrl[CTRL_EXEC_BIT];
	assign take = instr_valid && instr_ready;
	assign awready = !st_q.aw_got;
	assign wready = !st_q.w_got;
	assign arready = !st_q.rvalid;
	// The ready outputs follow state only, never a valid input, so no
	// combinational loop forms with a master that waits for ready first.
	assign rd_take = arvalid && arready;
	// A captured write runs only after the previous response is taken, so
	// a slow bready never loses a response.
	assign wr_exec = st_q.aw_got && st_q.w_got && !st_q.bvalid;
	// A skip stays armed until the next word is taken, however long the
	// fetch path pauses in between.
	assign skip_armed = (st_q.ex == EX_SKIP);

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err = 1'b0;
		if (reg_hit(araddr, OFF_CTRL)) begin
			rd_word[CTRL_W-1:0] = st_q.ctrl;
		end else if (reg_hit(araddr, OFF_STATUS)) begin
			rd_word[STAT_ZERO_BIT] = st_q.flags.zero_flag;
			rd_word[STAT_PWRDN_BIT] = st_q.flags.power_down_flag;
			rd_word[STAT_TMO_BIT] = st_q.flags.timeout_flag;
		end else if (reg_hit(araddr, OFF_WREG)) begin
			rd_word[7:0] = st_q.wreg;
		end else if (reg_hit(araddr, OFF_FADDR)) begin
			rd_word[FADDR_W-1:0] = st_q.faddr;
		end else if (reg_hit(araddr, OFF_FDATA)) begin
			rd_word[7:0] = file_sw_rd;
		end else if (reg_hit(araddr, OFF_WDOG)) begin
			rd_word[7:0] = wd_count;
		end else if (reg_hit(araddr, OFF_PRESC)) begin
			rd_word[7:0] = wd_presc;
		end else begin
			rd_err = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Software effects are applied first and instruction effects last, so
	// that an instruction in the same cycle as a register write wins.
	always_comb begin
		st_d = st_q;
		st_d.discard = 1'b0;
		wd_clear = 1'b0;
		fw_en = 1'b0;
		fw_addr = st_q.faddr;
		fw_data = st_q.w_data[7:0];

		if (awvalid && !st_q.aw_got) begin
			st_d.aw_got = 1'b1;
			st_d.aw_addr = awaddr;
		end
		if (wvalid && !st_q.w_got) begin
			st_d.w_got = 1'b1;
			st_d.w_data = wdata;
			st_d.w_strb = wstrb;
		end
		if (st_q.bvalid && bready) begin
			st_d.bvalid = 1'b0;
		end

		if (wr_exec) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = RESP_OKAY;
			if (reg_hit(st_q.aw_addr, OFF_CTRL)) begin
				if (st_q.w_strb[0]) begin
					st_d.ctrl = st_q.w_data[CTRL_W-1:0];
				end
			end else if (reg_hit(st_q.aw_addr, OFF_STATUS)) begin
				if (st_q.w_strb[0]) begin
					st_d.flags.zero_flag = st_q.w_data[STAT_ZERO_BIT];
					st_d.flags.power_down_flag = st_q.w_data[STAT_PWRDN_BIT];
					st_d.flags.timeout_flag = st_q.w_data[STAT_TMO_BIT];
				end
			end else if (reg_hit(st_q.aw_addr, OFF_WREG)) begin
				if (st_q.w_strb[0]) begin
					st_d.wreg = st_q.w_data[7:0];
				end
			end else if (reg_hit(st_q.aw_addr, OFF_FADDR)) begin
				if (st_q.w_strb[0]) begin
					st_d.faddr = st_q.w_data[FADDR_W-1:0];
				end
			end else if (reg_hit(st_q.aw_addr, OFF_FDATA)) begin
				fw_en = st_q.w_strb[0];
			end else if (reg_hit(st_q.aw_addr, OFF_WDOG) ||
				reg_hit(st_q.aw_addr, OFF_PRESC)) begin
				// Count and prescaler are read-only; such writes are accepted and dropped.
				st_d.bresp = RESP_OKAY;
			end else begin
				// An unmapped write changes nothing and is answered with an error.
				st_d.bresp = RESP_SLVERR;
			end
		end

		if (st_q.rvalid && rready) begin
			st_d.rvalid = 1'b0;
		end
		// Read data are captured when the address is taken, so rdata
		// stands unchanged however long rvalid waits for rready.
		if (rd_take) begin
			st_d.rvalid = 1'b1;
			st_d.rdata = rd_word;
			st_d.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
		end

		// A watchdog expiry drops the timeout flag, which reads as active low.
		if (wd_timeout) begin
			st_d.flags.timeout_flag = 1'b0;
		end

		if (take) begin
			if (skip_armed) begin
				// The prefetched word is dropped and nothing else changes.
				st_d.ex = EX_RUN;
				st_d.discard = 1'b1;
			end else begin
				case (dec.op)
					OP_WDOG_CLEAR: begin
						// The zero flag is not touched by a watchdog clear.
						wd_clear = 1'b1;
						st_d.flags.timeout_flag = 1'b1;
						st_d.flags.power_down_flag = 1'b1;
					end
					OP_DEC: begin
						st_d.flags.zero_flag = is_zero(dec_res);
						if (dec.dest) begin
							fw_en = 1'b1;
							fw_addr = dec.faddr;
							fw_data = dec_res;
						end else begin
							st_d.wreg = dec_res;
						end
					end
					OP_DEC_SKIP: begin
						if (dec.dest) begin
							fw_en = 1'b1;
							fw_addr = dec.faddr;
							fw_data = dec_res;
						end else begin
							st_d.wreg = dec_res;
						end
						if (is_zero(dec_res)) begin
							st_d.ex = EX_SKIP;
						end
					end
					default: begin
						st_d.ex = EX_RUN;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Exec enable comes up set so the fetch path runs straight after
	// reset; the watchdog stays off until software starts it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
			st_q.ctrl <= CTRL_RST;
			st_q.flags.timeout_flag <= STAT_TMO_RST;
			st_q.flags.power_down_flag <= STAT_PWRDN_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign bvalid = st_q.bvalid;
	assign bresp = st_q.bresp;
	assign rvalid = st_q.rvalid;
	assign rdata = st_q.rdata;
	assign rresp = st_q.rresp;
	assign skip_discard = st_q.discard;
	assign flags = st_q.flags;
	// The expiry pulse is passed on as it is and lasts one cycle.
	assign wdog_timeout = wd_timeout;

endmodule

//--- verif/wcd_exec_props.sv
// Concurrent checks on the executor's ports, bound to the executor module wcd_exec.
module wcd_exec_props
	import wcd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic [13:0] instr_word,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic skip_discard,
	input wire wcd_flags_s flags,
	input wire logic wdog_timeout
);
	// ------------------------------------------------------------------
	// Decoded view of the instruction port
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire logic take = instr_valid && instr_ready;
	wire logic clr = take && instr_word == OPC_WDOG_CLEAR;
	wire logic dec = take && instr_word[13:8] == OPC_DEC;
	wire logic dsk = take && instr_word[13:8] == OPC_DEC_SKIP;

	// A discarded word has no effect, so both clear checks let skip_discard excuse it.
	a_clear_flags:
	assert property (clr |=> skip_discard || (flags.timeout_flag && flags.power_down_flag))
		else $error("watchdog clear left a status flag low");
	a_clear_wdog:
	assert property (clr |=> skip_discard || !wdog_timeout)
		else $error("watchdog expired right after a clear");
	// An expiry pulse in the taking cycle, or a register write executed at
	// the same edge, changes flags on its own, so either one excuses the check.
	a_dec_keep_flags:
	assert property (dec && !wdog_timeout |=> $rose(bvalid) ||
		$stable({flags.timeout_flag, flags.power_down_flag}))
		else $error("decrement changed a flag other than zero");
	a_skip_flags:
	assert property (dsk && !wdog_timeout |=> $rose(bvalid) || $stable(flags))
		else $error("decrement-skip changed a flag");
	a_discard_cause:
	assert property (skip_discard |-> $past(take))
		else $error("discard without a taken word");
	a_discard_single:
	assert property (skip_discard |=> !skip_discard)
		else $error("discard lasted two cycles");
	a_rd_slverr:
	assert property (arvalid && arready && araddr == 8'h1c |-> ##[1:2]
		(rvalid && rresp == RESP_SLVERR && rdata == 32'h0))
		else $error("unmapped read not answered with an error");
	a_ar_refused:
	assert property (rvalid |-> !arready)
		else $error("read address taken while a reply waits");
	a_wr_resp:
	assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##[1:2] bvalid)
		else $error("write response missing");
endmodule

bind wcd_exec wcd_exec_props i_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
	.bvalid, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .instr_word, .instr_valid,
	.instr_ready, .skip_discard, .flags, .wdog_timeout);

//--- verif/wcd_fetch_model.sv
// Behavioural model of the instruction fetch path feeding the executor.
module wcd_fetch_model
	import wcd_pkg::*;
(
	input wire logic aclk,
	input wire logic instr_ready,
	output logic [13:0] instr_word,
	output logic instr_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		instr_word = 14'h0000;
		instr_valid = 1'b0;
	end
	// Called just after a rising edge; the word stands until the edge that takes it.
	task automatic send(input logic [13:0] w, input int gap);
		if (gap > 0) begin
			idle();
			repeat (gap) @(posedge aclk);
		end
		instr_word <= w;
		instr_valid <= 1'b1;
		do @(posedge aclk); while (instr_ready !== 1'b1);
	endtask
	// A released word line shows the inverse so stale data is never mistaken for a word.
	task automatic idle();
		instr_valid <= 1'b0;
		instr_word <= ~instr_word;
	endtask
endmodule

//--- verif/wcd_exec_test.sv
// Self-checking testbench of the executor through its register bus and instruction port.
module wcd_exec_test
	import wcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [13:0] w0;
		logic [13:0] w1;
		logic [7:0] ew;
		logic [7:0] ef;
		logic ez;
		logic [1:0] ed;
	} wcd_tb_step_s;
	localparam wcd_tb_step_s STEPS [9] = '{
		'{14'h037f, 14'h0, 8'h01, 8'h02, 1'b0, 2'd0},
		'{14'h03ff, 14'h0, 8'h01, 8'h01, 1'b0, 2'd0},
		'{14'h03ff, 14'h0, 8'h01, 8'h00, 1'b1, 2'd0},
		'{14'h037f, 14'h0, 8'hff, 8'h00, 1'b0, 2'd0},
		'{14'h0300, 14'h0, 8'h00, 8'h00, 1'b1, 2'd0},
		'{14'h0b7f, 14'h0, 8'hff, 8'h00, 1'b1, 2'd0},
		'{14'h0bff, 14'h037f, 8'hfe, 8'hff, 1'b0, 2'd0},
		'{14'h0b80, 14'h03ff, 8'hfe, 8'hff, 1'b0, 2'd1},
		'{14'h0300, 14'h0, 8'hff, 8'hff, 1'b0, 2'd1}};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [1:0] r;
	logic [31:0] rdata;
	logic [31:0] v;
	logic bvalid, rvalid, awready, wready, arready;
	logic instr_ready, instr_valid, skip_discard, wdog_timeout;
	logic [13:0] instr_word;
	wcd_flags_s flags;
	int error_cnt = 0;
	int n_tests = 0;
	int n_disc = 0;
	int k = 0;
	// One full watchdog period: every prescaler step times every count step.
	localparam int WDOG_SPAN = (int'(PRESC_LAST) + 1) * (int'(WDOG_LAST) + 1);
	always #4 aclk = ~aclk;
	always @(posedge aclk) if (skip_discard === 1'b1) n_disc <= n_disc + 1;
	wcd_exec i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .instr_word, .instr_valid, .instr_ready, .skip_discard, .flags,
		.wdog_timeout);
	wcd_fetch_model i_fetch (.aclk, .instr_ready, .instr_word, .instr_valid);

	// ------------------------------------------------------------------
	// Bus and compare tasks, each entered just after a rising edge
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				rs = rresp;
				break;
			end
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a, v, r);
		chk($sformatf("rdata %h", a), v, e);
		chk($sformatf("rresp %h", a), r, RESP_OKAY);
	endtask
	// Two words back to back, then the fetch path goes idle.
	task automatic go(input logic [13:0] w0, input logic [13:0] w1);
		i_fetch.send(w0, 0);
		i_fetch.send(w1, 0);
		i_fetch.idle();
		@(posedge aclk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// The expiry test alone spans one watchdog period of 65,536 cycles.
	initial begin
		repeat (80000) @(posedge aclk);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rc(OFF_CTRL, 32'h1);
		rc(OFF_STATUS, 32'h18);
		rd(8'h1c, v, r);
		chk("unmapped rresp", r, RESP_SLVERR);
		chk("unmapped rdata", v, 32'h0);
		wr(8'h20, 32'h1, r);
		chk("unmapped bresp", r, RESP_SLVERR);
		wr(OFF_FADDR, 32'h00, r);
		wr(OFF_FDATA, 32'h01, r);
		wr(OFF_FADDR, 32'h7f, r);
		wr(OFF_FDATA, 32'h02, r);
		wr(OFF_WREG, 32'h55, r);
		foreach (STEPS[i]) begin
			go(STEPS[i].w0, STEPS[i].w1);
			rc(OFF_WREG, STEPS[i].ew);
			rc(OFF_FDATA, STEPS[i].ef);
			chk("flags", flags, {2'b11, STEPS[i].ez});
			chk("discards", n_disc, STEPS[i].ed);
		end
		wr(OFF_STATUS, 32'h04, r);
		wr(OFF_CTRL, 32'h3, r);
		repeat (600) @(posedge aclk);
		rd(OFF_WDOG, v, r);
		chk("watchdog running", v != 32'h0, 1'b1);
		go(OPC_WDOG_CLEAR, 14'h0);
		rc(OFF_WDOG, 32'h0);
		wr(OFF_CTRL, 32'h1, r);
		rd(OFF_PRESC, v, r);
		chk("prescaler restarted", v < 32'h20, 1'b1);
		chk("flags", flags, 3'b111);
		wr(OFF_CTRL, 32'h3, r);
		go(OPC_WDOG_CLEAR, 14'h0);
		// The bench is now two edges past the one that took the clear.
		k = 2;
		do begin
			@(posedge aclk);
			k++;
		end while (wdog_timeout !== 1'b1 && k <= WDOG_SPAN + 8);
		chk("expiry edge", k, WDOG_SPAN + 1);
		@(posedge aclk);
		chk("flags after expiry", flags, 3'b011);
		go(OPC_WDOG_CLEAR, 14'h0);
		chk("flags", flags, 3'b111);
		final_report();
	end
endmodule
